// *** inc/ufc_pkg.sv ***
// Shared constants for the UART FIFO control block
package ufc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] UFC_IDX_INT_ENABLE = 4'h1;
	localparam logic [3:0] UFC_IDX_FIFO_CTRL  = 4'h2;
	localparam logic [3:0] UFC_IDX_STATUS     = 4'h8;
	localparam int         UFC_ADDR_W         = 8;

	// Field positions of fifo_control
	localparam int UFC_FC_ENABLE   = 0;
	localparam int UFC_FC_RX_FLUSH = 1;
	localparam int UFC_FC_TX_FLUSH = 2;
	localparam int UFC_FC_DMA_MODE = 3;
	localparam int UFC_FC_TX_TRIG  = 4;
	localparam int UFC_FC_RX_TRIG  = 6;

	// Field positions of interrupt_enable
	localparam int UFC_IE_RX_DATA = 0;
	localparam int UFC_IE_TX      = 1;

	// Reset values
	localparam logic [7:0] UFC_FC_RESET = 8'h00;
	localparam logic [1:0] UFC_IE_RESET = 2'h0;

	// Depths of the two variants
	localparam int UFC_CNT_W        = 7;
	localparam int UFC_DEPTH_DEEP   = 64;
	localparam int UFC_DEPTH_SHALLOW = 16;

	// Receive thresholds for codes 00, 01, 10, 11
	localparam logic [6:0] UFC_RX_DEEP_0 = 7'h08;
	localparam logic [6:0] UFC_RX_DEEP_1 = 7'h10;
	localparam logic [6:0] UFC_RX_DEEP_2 = 7'h38;
	localparam logic [6:0] UFC_RX_DEEP_3 = 7'h3c;
	localparam logic [6:0] UFC_RX_SHAL_0 = 7'h01;
	localparam logic [6:0] UFC_RX_SHAL_1 = 7'h04;
	localparam logic [6:0] UFC_RX_SHAL_2 = 7'h08;
	localparam logic [6:0] UFC_RX_SHAL_3 = 7'h0e;

	// Transmit thresholds (empty spaces) for codes 00, 01, 10, 11
	localparam logic [6:0] UFC_TX_DEEP_0 = 7'h08;
	localparam logic [6:0] UFC_TX_DEEP_1 = 7'h10;
	localparam logic [6:0] UFC_TX_DEEP_2 = 7'h20;
	localparam logic [6:0] UFC_TX_DEEP_3 = 7'h38;

	// Identification codes returned at the shared address
	localparam logic [3:0] UFC_ID_NONE    = 4'h1;
	localparam logic [3:0] UFC_ID_TX      = 4'h2;
	localparam logic [3:0] UFC_ID_RX_DATA = 4'h4;
	localparam logic [1:0] UFC_ID_FIFO_ON = 2'h3;
endpackage

// *** rtl/ufc_fifo_control.sv ***
// FIFO control register and DMA request logic for one UART channel
// How it works
// [RULE_01] Deep receive trigger codes 11,10,01,00 give 60,56,16,8; default 8.
// [RULE_02] Receive count equal to trigger raises data interrupt when enabled.
// [RULE_03] Deep transmit trigger codes 11,10,01,00 give 56,32,16,8 spaces.
// [RULE_04] Empty spaces above transmit threshold raise interrupt and DMA request; the request follows this in mode 1 only, mode 0 waits for an empty FIFO.
// [RULE_05] Shallow variant ignores the transmit trigger bits.
// [RULE_06] DMA mode bit selects block mode 1, only with FIFOs on.
// [RULE_07] Mode 0: receive request low while any character is buffered.
// [RULE_08] Mode 1: receive request low at trigger or timeout, high when empty.
// [RULE_09] Transmit flush bit empties transmit FIFO, then clears itself.
// [RULE_10] Receive flush bit empties receive FIFO, then clears itself.
// [RULE_11] Enable bit turns both FIFOs on; zero, the default, turns off.
// [RULE_12] Other fields change only when the write enables FIFOs.
// [RULE_13] Control is write-only; reads there return interrupt identification.
// [RULE_14] Master reset clears every control field and the counts.
//
// The implementer's own choice: the APB slave port.
module ufc_fifo_control
	import ufc_pkg::*;
#(
	parameter bit DEEP = 1'b1
) (
	// APB slave
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [UFC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Character traffic from the channel datapath
	input  wire logic                  rx_push,
	input  wire logic                  rx_pop,
	input  wire logic                  tx_push,
	input  wire logic                  tx_pop,
	input  wire logic                  rx_timeout,
	// DMA request pins, active low
	output logic                       rx_dma_request_n,
	output logic                       tx_dma_request_n,
	// Interrupt requests and control state for the datapath
	output logic                       rx_data_irq,
	output logic                       tx_irq,
	output logic                       fifo_enable,
	output logic                       dma_mode,
	output logic                       rx_flush,
	output logic                       tx_flush
);
	localparam logic [UFC_CNT_W-1:0] DEPTH = DEEP ?
		UFC_CNT_W'(UFC_DEPTH_DEEP) : UFC_CNT_W'(UFC_DEPTH_SHALLOW);

	logic [7:0]           fc_reg, fc_next;
	logic [1:0]           ie_reg, ie_next;
	logic                 rx_flush_reg, rx_flush_next;
	logic                 tx_flush_reg, tx_flush_next;
	logic                 pready_reg, pready_next;
	logic                 pslverr_reg, pslverr_next;
	logic [31:0]          prdata_reg, prdata_next;
	logic                 rx_req_reg, rx_req_next;
	logic                 tx_req_reg, tx_req_next;
	logic                 rx_irq_reg, rx_irq_next;
	logic                 tx_irq_reg, tx_irq_next;
	logic                 access;
	logic                 wr_done;
	logic [3:0]           index;
	logic                 aligned;
	logic [UFC_CNT_W-1:0] rx_count, tx_count, limit, spaces;
	logic [UFC_CNT_W-1:0] rx_trig, tx_trig;
	logic                 fifo_on, mode1;
	logic [3:0]           id_code;

	assign access  = psel && penable && !pready_reg;
	assign wr_done = psel && penable && pready_reg && pwrite;
	assign index   = paddr[5:2];
	assign aligned = (paddr[1:0] == 2'h0) && (paddr[UFC_ADDR_W-1:6] == '0);
	assign fifo_on = fc_reg[UFC_FC_ENABLE];
	assign mode1   = fifo_on && fc_reg[UFC_FC_DMA_MODE]; // RULE_06
	// Without FIFOs each side behaves as a one-character holding register
	assign limit   = fifo_on ? DEPTH : UFC_CNT_W'(1); // RULE_11
	assign spaces  = limit - tx_count;

	// Threshold tables; shallow part has no transmit threshold
	always_comb begin
		unique case (fc_reg[UFC_FC_RX_TRIG +: 2])
			2'h0: rx_trig = DEEP ? UFC_RX_DEEP_0 : UFC_RX_SHAL_0; // RULE_01
			2'h1: rx_trig = DEEP ? UFC_RX_DEEP_1 : UFC_RX_SHAL_1;
			2'h2: rx_trig = DEEP ? UFC_RX_DEEP_2 : UFC_RX_SHAL_2;
			2'h3: rx_trig = DEEP ? UFC_RX_DEEP_3 : UFC_RX_SHAL_3;
		endcase
		unique case (fc_reg[UFC_FC_TX_TRIG +: 2])
			2'h0: tx_trig = UFC_TX_DEEP_0; // RULE_03
			2'h1: tx_trig = UFC_TX_DEEP_1;
			2'h2: tx_trig = UFC_TX_DEEP_2;
			2'h3: tx_trig = UFC_TX_DEEP_3;
		endcase
	end

	// Identification shown at the shared address; receive has priority
	always_comb begin
		if (rx_irq_reg) begin
			id_code = UFC_ID_RX_DATA;
		end else if (tx_irq_reg) begin
			id_code = UFC_ID_TX;
		end else begin
			id_code = UFC_ID_NONE;
		end
	end

	// Bus side: one wait state, then the answer; writes land with pready
	always_comb begin
		fc_next       = fc_reg;
		ie_next       = ie_reg;
		rx_flush_next = 1'b0;
		tx_flush_next = 1'b0;
		pready_next   = access;
		pslverr_next  = 1'b0;
		prdata_next   = prdata_reg;
		if (access) begin
			prdata_next  = 32'h0000_0000;
			pslverr_next = !aligned || !(index == UFC_IDX_INT_ENABLE ||
				index == UFC_IDX_FIFO_CTRL ||
				(index == UFC_IDX_STATUS && !pwrite));
			if (aligned && !pwrite) begin
				unique case (index)
					UFC_IDX_INT_ENABLE: prdata_next = {30'h0, ie_reg};
					UFC_IDX_FIFO_CTRL: prdata_next = {24'h0,
						fifo_on ? UFC_ID_FIFO_ON : 2'h0,
						2'h0, id_code}; // RULE_13
					UFC_IDX_STATUS: prdata_next = {8'h0,
						1'b0, tx_count, 1'b0, rx_count,
						6'h0, mode1, fifo_on};
					default: prdata_next = 32'h0000_0000;
				endcase
			end
		end
		if (wr_done && aligned && index == UFC_IDX_INT_ENABLE) begin
			ie_next = pwdata[1:0];
		end
		if (wr_done && aligned && index == UFC_IDX_FIFO_CTRL) begin
			fc_next[UFC_FC_ENABLE] = pwdata[UFC_FC_ENABLE]; // RULE_11
			// Fields follow only a write that leaves FIFOs on
			if (pwdata[UFC_FC_ENABLE]) begin // RULE_12
				fc_next[UFC_FC_DMA_MODE] = pwdata[UFC_FC_DMA_MODE];
				fc_next[UFC_FC_RX_TRIG +: 2] = pwdata[UFC_FC_RX_TRIG +: 2];
				if (DEEP) begin // RULE_05
					fc_next[UFC_FC_TX_TRIG +: 2] =
						pwdata[UFC_FC_TX_TRIG +: 2];
				end
				rx_flush_next = pwdata[UFC_FC_RX_FLUSH]; // RULE_10
				tx_flush_next = pwdata[UFC_FC_TX_FLUSH]; // RULE_09
			end
			// Leaving FIFO mode also discards both queues
			if (fifo_on && !pwdata[UFC_FC_ENABLE]) begin
				rx_flush_next = 1'b1;
				tx_flush_next = 1'b1;
			end
		end
		// Flush bits are never stored: they act once and read back zero
		fc_next[UFC_FC_RX_FLUSH] = 1'b0; // RULE_10
		fc_next[UFC_FC_TX_FLUSH] = 1'b0; // RULE_09
	end

	// Request pins and interrupts, all registered
	always_comb begin
		rx_req_next = rx_req_reg;
		if (!mode1) begin
			rx_req_next = (rx_count != '0); // RULE_07
		end else if (rx_count == '0) begin
			rx_req_next = 1'b0; // RULE_08
		end else if (rx_count == rx_trig || rx_timeout) begin
			rx_req_next = 1'b1; // RULE_08
		end
		tx_req_next = tx_req_reg;
		if (!mode1) begin
			tx_req_next = (tx_count == '0);
		end else if (tx_count == limit) begin
			tx_req_next = 1'b0;
		end else if (DEEP ? (spaces > tx_trig) : (tx_count == '0)) begin
			tx_req_next = 1'b1; // RULE_04
		end
		// Level-style interrupt: holds until reads drop below trigger
		rx_irq_next = ie_reg[UFC_IE_RX_DATA] &&
			(fifo_on ? (rx_count >= rx_trig) : (rx_count != '0)); // RULE_02
		tx_irq_next = ie_reg[UFC_IE_TX] &&
			((fifo_on && DEEP) ? (spaces > tx_trig)
				: (tx_count == '0)); // RULE_04
		if (rx_flush_reg) begin
			rx_req_next = 1'b0;
		end
	end

	// Registers; master reset returns every field to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fc_reg       <= UFC_FC_RESET; // RULE_14
			ie_reg       <= UFC_IE_RESET;
			rx_flush_reg <= 1'b0;
			tx_flush_reg <= 1'b0;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
			prdata_reg   <= 32'h0000_0000;
			rx_req_reg   <= 1'b0;
			tx_req_reg   <= 1'b0;
			rx_irq_reg   <= 1'b0;
			tx_irq_reg   <= 1'b0;
		end else begin
			fc_reg       <= fc_next;
			ie_reg       <= ie_next;
			rx_flush_reg <= rx_flush_next;
			tx_flush_reg <= tx_flush_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
			prdata_reg   <= prdata_next;
			rx_req_reg   <= rx_req_next;
			tx_req_reg   <= tx_req_next;
			rx_irq_reg   <= rx_irq_next;
			tx_irq_reg   <= tx_irq_next;
		end
	end

	// Occupancy of each queue; shift registers live outside and keep data
	ufc_level_count #(.CNT_W(UFC_CNT_W)) u_rx_level (
		.pclk    (pclk),
		.presetn (presetn),
		.push    (rx_push),
		.pop     (rx_pop),
		.flush   (rx_flush_reg), // RULE_10
		.limit   (limit),
		.count   (rx_count)
	);

	ufc_level_count #(.CNT_W(UFC_CNT_W)) u_tx_level (
		.pclk    (pclk),
		.presetn (presetn),
		.push    (tx_push),
		.pop     (tx_pop),
		.flush   (tx_flush_reg), // RULE_09
		.limit   (limit),
		.count   (tx_count)
	);

	assign prdata           = prdata_reg;
	assign pready           = pready_reg;
	assign pslverr          = pslverr_reg;
	assign rx_dma_request_n = !rx_req_reg;
	assign tx_dma_request_n = !tx_req_reg;
	assign rx_data_irq      = rx_irq_reg;
	assign tx_irq           = tx_irq_reg;
	assign fifo_enable      = fc_reg[UFC_FC_ENABLE];
	assign dma_mode         = fc_reg[UFC_FC_DMA_MODE];
	assign rx_flush         = rx_flush_reg;
	assign tx_flush         = tx_flush_reg;
endmodule

// *** rtl/ufc_level_count.sv ***
// Occupancy counter for one FIFO, with flush and a variable limit
module ufc_level_count
	import ufc_pkg::*;
#(
	parameter int CNT_W = UFC_CNT_W
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Traffic and control
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic             flush,
	input  wire logic [CNT_W-1:0] limit,
	// Level
	output logic      [CNT_W-1:0] count
);
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic             do_push;
	logic             do_pop;

	// Overfull pushes and empty pops are dropped; flush beats both
	always_comb begin
		do_push    = push && (count_reg < limit);
		do_pop     = pop && (count_reg != '0);
		count_next = count_reg;
		if (flush) begin
			count_next = '0;
		end else if (do_push && !do_pop) begin
			count_next = count_reg + CNT_W'(1);
		end else if (do_pop && !do_push) begin
			count_next = count_reg - CNT_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count = count_reg;
endmodule

// *** tb/ufc_dma_model.sv ***
// DMA controller model that drains receive and fills transmit
module ufc_dma_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pacing from the bench
	input wire logic go,
	input wire logic pace,
	// Request pins and transfer strobes
	input wire logic rx_dma_request_n,
	input wire logic tx_dma_request_n,
	output logic     rx_pop,
	output logic     tx_push
);
	timeunit 1ns;
	timeprecision 100ps;
	// One transfer per paced cycle; overshoot by up to two is refused by the block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_pop <= 1'b0;
			tx_push <= 1'b0;
		end else begin
			rx_pop <= go & pace & ~rx_dma_request_n;
			tx_push <= go & pace & ~tx_dma_request_n;
		end
	end
endmodule

// *** tb/ufc_fifo_control_checker.sv ***
// Port checker for the FIFO control block
module ufc_fifo_control_checker
	import ufc_pkg::*;
(
	// Clock, reset and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Traffic and outputs
	input wire logic        rx_push,
	input wire logic        tx_push,
	input wire logic        rx_timeout,
	input wire logic        rx_dma_request_n,
	input wire logic        tx_dma_request_n,
	input wire logic        fifo_enable,
	input wire logic        dma_mode,
	input wire logic        rx_flush,
	input wire logic        tx_flush
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed write access
	logic wr;
	assign wr = psel & penable & pready & pwrite;
	sequence s_tx_drained;
		tx_flush ##1 (!tx_push) [*3];
	endsequence
	sequence s_rx_drained;
		rx_flush ##1 (!rx_push && !rx_timeout) [*3];
	endsequence
	property p_ready;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("bad ready");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_en;
		$changed(fifo_enable) |-> $past(wr);
	endproperty
	a_en: assert property (p_en) else $error("enable moved");
	property p_mode;
		$changed(dma_mode) |-> $past(wr && pwdata[0]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode moved");
	property p_self_clear;
		rx_flush || tx_flush |=> !rx_flush && !tx_flush;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("flush held");
	property p_flush_on;
		rx_flush || tx_flush |-> fifo_enable || $past(fifo_enable);
	endproperty
	a_flush_on: assert property (p_flush_on) else $error("flush while off");
	property p_flush_cause;
		$rose(rx_flush || tx_flush) |-> $past(wr) || $past(wr, 2);
	endproperty
	a_flush_cause: assert property (p_flush_cause) else $error("flush uncaused");
	property p_tx_empty;
		s_tx_drained |-> !tx_dma_request_n;
	endproperty
	a_tx_empty: assert property (p_tx_empty) else $error("tx request off");
	property p_rx_idle;
		s_rx_drained |-> rx_dma_request_n;
	endproperty
	a_rx_idle: assert property (p_rx_idle) else $error("rx request on");
endmodule
bind ufc_fifo_control ufc_fifo_control_checker u_chk (.*);

// *** tb/ufc_fifo_control_tb.sv ***
// Self-checking bench for the FIFO control block
module ufc_fifo_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [31:0] seed = 32'hfca8;
	logic tx_irq_s;
	logic rx_dma_request_n, tx_dma_request_n, rx_data_irq, tx_irq;
	logic fifo_enable, dma_mode, rx_flush, tx_flush, go, pace, prx, ptx;
	logic [4:0] tr;
	int errors, tests_run, t;
	ufc_fifo_control u_dut (.*, .rx_push(tr[3]), .rx_pop(tr[2] | prx),
		.tx_push(tr[1] | ptx), .tx_pop(tr[0]), .rx_timeout(tr[4]));
	// Shallow variant on the same bus; only its transmit interrupt is watched
	ufc_fifo_control #(.DEEP(1'b0)) u_dut_shallow (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
		.pready(), .pslverr(), .rx_push(tr[3]), .rx_pop(tr[2]),
		.tx_push(tr[1] | ptx), .tx_pop(tr[0]), .rx_timeout(tr[4]),
		.rx_dma_request_n(), .tx_dma_request_n(), .rx_data_irq(),
		.tx_irq(tx_irq_s), .fifo_enable(), .dma_mode(), .rx_flush(),
		.tx_flush());
	ufc_dma_model u_dma (.pclk(pclk), .presetn(presetn), .go(go),
		.pace(pace), .rx_dma_request_n(rx_dma_request_n),
		.tx_dma_request_n(tx_dma_request_n), .rx_pop(prx), .tx_push(ptx));
	// Clock and random pacing
	always #4 pclk = ~pclk;
	// Xorshift step; the fixed start value keeps every run repeatable
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	always @(posedge pclk) begin
		seed <= xs(seed);
		pace <= seed[0];
	end
	function automatic int rxt(input int c);
		return c == 3 ? 'h3c : c == 2 ? 'h38 : c == 1 ? 'h10 : 'h08;
	endfunction
	function automatic int txt(input int c);
		return c == 3 ? 'h38 : c == 2 ? 'h20 : c == 1 ? 'h10 : 'h08;
	endfunction
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	// Bus cycle; read data is taken at the edge that sees pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		if (n >= 50) chk("pready", 0, 1);
		if (pslverr === 1'b1) r = 32'hdead;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pulse(input int b, input int n);
		repeat (n) begin
			@(posedge pclk);
			tr[b] <= 1'b1;
		end
		@(posedge pclk);
		tr[b] <= 1'b0;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
	endtask
	task conclude;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog well beyond the thousand or so cycles the run needs
	initial begin
		#160000;
		errors++;
		conclude();
	end
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, tr, go} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(negedge pclk);
		chk("tx_req", tx_dma_request_n, 0);
		chk("reset0", {fifo_enable, dma_mode, rx_dma_request_n,
			rx_data_irq, tx_irq, rx_flush, tx_flush}, 7'h10);
		apb(0, 8'h08, 0);
		chk("ident", r, 32'h01);
		for (int i = 0; i < 4; i++) begin
			apb(1, 8'h08, (seed & 32'hfe) | 32'h08);
			apb(0, 8'h20, 0);
			chk("off", r, 0);
			chk("off_mode", dma_mode, 0);
		end
		apb(1, 8'h04, 1);
		for (int i = 0; i < 4; i++) begin
			t = rxt(i);
			apb(1, 8'h08, {i[1:0], 6'h03});
			apb(0, 8'h20, 0);
			chk("rx_cnt", r[14:8], 0);
			pulse(3, t - 1);
			chk("rx_irq", rx_data_irq, 0);
			pulse(3, 1);
			chk("rx_irq", rx_data_irq, 1);
			apb(0, 8'h08, 0);
			chk("ident", r, 32'hc4);
		end
		apb(1, 8'h04, 2);
		for (int i = 0; i < 4; i++) begin
			t = txt(i);
			apb(1, 8'h08, {2'h0, i[1:0], 4'hd});
			pulse(1, 'h40 - t);
			chk("tx_irq", tx_irq, 0);
			pulse(0, 1);
			chk("tx_irq", tx_irq, 1);
			chk("tx_irq_s", tx_irq_s, 0);
			pulse(1, t + 1);
			chk("tx_req", tx_dma_request_n, 1);
			apb(0, 8'h20, 0);
			chk("status", {r[22:16], r[1:0]}, 9'h103);
		end
		apb(1, 8'h08, 8'h03);
		pulse(3, 1);
		chk("rx_req", rx_dma_request_n, 0);
		pulse(2, 1);
		chk("rx_req", rx_dma_request_n, 1);
		apb(1, 8'h08, 8'h0f);
		pulse(3, 7);
		chk("rx_req", rx_dma_request_n, 1);
		pulse(3, 1);
		chk("rx_req", rx_dma_request_n, 0);
		pulse(2, 7);
		chk("rx_req", rx_dma_request_n, 0);
		pulse(4, 1);
		go <= 1'b1;
		repeat (300) @(posedge pclk);
		go <= 1'b0;
		apb(0, 8'h20, 0);
		chk("counts", r[22:8], 15'h4000);
		apb(1, 8'h08, 0);
		apb(0, 8'h20, 0);
		chk("off", r, 0);
		apb(0, 8'h10, 0);
		chk("unmapped", r, 32'hdead);
		// Mid-run master reset with FIFOs on, block mode and a live request
		apb(1, 8'h08, 8'h09);
		pulse(3, 8);
		chk("pre_reset", {fifo_enable, dma_mode, rx_dma_request_n},
			3'h6);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("reset", {fifo_enable, dma_mode, rx_dma_request_n, tx_flush},
			4'h2);
		apb(0, 8'h20, 0);
		chk("reset_st", r, 0);
		conclude();
	end
endmodule
